// ### design/reference_clock_output_select.sv
// register file and two reference clock output paths
// assumes synchronous register port, one-cycle read latency, board resolves the pin from the enable
`timescale 1ns/1ps
`default_nettype none
//
// Contract
// RULE_01: first output enable low tri-states first output; high drives it; resets high.
// RULE_02: second output enable low tri-states second output; high drives it; resets high.
// RULE_03: first external input rate bit zero means T1, one means E1; resets zero.
// RULE_04: second external input rate bit zero means T1, one means E1; resets zero.
// RULE_05: first selector codes 0 to 16 pick that channel; resets to channel 1.
// RULE_06: second selector codes 0 to 16 pick that channel; resets to channel 1.
// RULE_07: selector codes 17 to 31 route the external clock input instead.
// RULE_08: bit 7 of each configuration register is reserved and does nothing.
// RULE_09: reads return last written fields; reserved bit reads zero.
module reference_clock_output_select
    import ref_clock_pkg::*;
#(
    parameter int CHANNELS = NUM_CHANNELS
)
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [DATA_W-1:0] reg_rdata,
    input wire logic [CHANNELS-1:0] recovered_clk,
    input wire logic ext_clock_in_a,
    input wire logic ext_clock_in_b,
    output logic ref_clock_out_a,
    output logic ref_clock_out_a_oe,
    output logic ref_clock_out_b,
    output logic ref_clock_out_b_oe,
    output logic ext_input_a_rate_sel,
    output logic ext_input_b_rate_sel
);

    // ------------------------------------------------------------
    // register state
    // ------------------------------------------------------------
    typedef struct packed {
        ref_cfg_s primary;
        ref_cfg_s secondary;
        logic [DATA_W-1:0] rdata;
    } regs_state_s;

    regs_state_s st_q;
    regs_state_s st_d;

    function automatic logic [DATA_W-1:0] pack_cfg(input ref_cfg_s c);
        logic [DATA_W-1:0] v;
        v = '0; // RULE_08 RULE_09
        v[ENABLE_BIT] = c.enable;
        v[RATE_BIT] = c.rate_e1;
        v[SEL_LSB +: SEL_W] = c.select;
        return v;
    endfunction : pack_cfg

    function automatic ref_cfg_s unpack_cfg(input logic [DATA_W-1:0] v);
        ref_cfg_s c;
        // reserved bit dropped: storing it would let software see a value with no effect
        c.enable = v[ENABLE_BIT];
        c.rate_e1 = v[RATE_BIT];
        c.select = v[SEL_LSB +: SEL_W];
        return c;
    endfunction : unpack_cfg

    always_comb
    begin
        st_d = st_q;
        st_d.rdata = READ_UNMAPPED;
        if (reg_write)
        begin
            if (reg_addr == PRIMARY_CFG_ADDR)
            begin
                st_d.primary = unpack_cfg(reg_wdata); // RULE_01 RULE_03 RULE_05
            end
            else if (reg_addr == SECONDARY_CFG_ADDR)
            begin
                st_d.secondary = unpack_cfg(reg_wdata); // RULE_02 RULE_04 RULE_06
            end
        end
        if (reg_read)
        begin
            if (reg_addr == PRIMARY_CFG_ADDR)
            begin
                st_d.rdata = pack_cfg(st_q.primary); // RULE_09
            end
            else if (reg_addr == SECONDARY_CFG_ADDR)
            begin
                st_d.rdata = pack_cfg(st_q.secondary); // RULE_09
            end
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            st_q <= '{primary: CFG_RESET, secondary: CFG_RESET, rdata: READ_UNMAPPED};
        end
        else
        begin
            st_q <= st_d;
        end
    end

    assign reg_rdata = st_q.rdata;

    // ------------------------------------------------------------
    // output paths
    // ------------------------------------------------------------
    ref_cfg_if cfg_a ();
    ref_cfg_if cfg_b ();

    assign cfg_a.cfg = st_q.primary;
    assign cfg_b.cfg = st_q.secondary;

    // clocks pass through one flop each; fine for level sampling, not a jitter-clean path
    ref_source_mux #(.CHANNELS(CHANNELS)) mux_a (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .cfg_port(cfg_a.sink),
        .recovered_clk(recovered_clk),
        .ext_clock_in(ext_clock_in_a),
        .ref_out(ref_clock_out_a),
        .ref_oe(ref_clock_out_a_oe),
        .ext_is_e1(ext_input_a_rate_sel)
    );

    ref_source_mux #(.CHANNELS(CHANNELS)) mux_b (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .cfg_port(cfg_b.sink),
        .recovered_clk(recovered_clk),
        .ext_clock_in(ext_clock_in_b),
        .ref_out(ref_clock_out_b),
        .ref_oe(ref_clock_out_b_oe),
        .ext_is_e1(ext_input_b_rate_sel)
    );

endmodule : reference_clock_output_select
`default_nettype wire

// ### pkg/ref_clock_pkg.sv
// register map, field layout and reset values for reference clock output selection
// assumes a byte-wide register port with one-cycle read latency
package ref_clock_pkg;

    localparam int ADDR_W = 12;
    localparam int DATA_W = 8;
    localparam int SEL_W = 5;
    localparam int NUM_CHANNELS = 17;

    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [11:0] PRIMARY_CFG_ADDR = 12'h240;
    localparam logic [11:0] SECONDARY_CFG_ADDR = 12'h244;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int RESERVED_BIT = 7;
    localparam int ENABLE_BIT = 6;
    localparam int RATE_BIT = 5;
    localparam int SEL_LSB = 0;

    // ------------------------------------------------------------
    // reset values and codes
    // ------------------------------------------------------------
    localparam logic ENABLE_RESET = 1'b1;
    localparam logic RATE_RESET = 1'b0;
    localparam logic [4:0] SEL_RESET = 5'h01;
    localparam logic [4:0] SEL_LAST_CHANNEL = 5'h10;
    localparam logic [7:0] READ_UNMAPPED = 8'h00;

    typedef struct packed {
        logic enable;
        logic rate_e1;
        logic [4:0] select;
    } ref_cfg_s;

    localparam ref_cfg_s CFG_RESET = '{enable: ENABLE_RESET, rate_e1: RATE_RESET, select: SEL_RESET};

endpackage : ref_clock_pkg

// ### pkg/ref_cfg_if.sv
// carries one output's configuration from the register file to its selector
// assumes both ends share sys_clk
`timescale 1ns/1ps
`default_nettype none
interface ref_cfg_if;
    import ref_clock_pkg::*;
    ref_cfg_s cfg;
    modport source (output cfg);
    modport sink (input cfg);
endinterface : ref_cfg_if
`default_nettype wire

// ### design/ref_source_mux.sv
// one reference output path: source selection and output enable
// assumes recovered clocks and external inputs are sampled as synchronous levels
`timescale 1ns/1ps
`default_nettype none
module ref_source_mux
    import ref_clock_pkg::*;
#(
    parameter int CHANNELS = NUM_CHANNELS
)
(
    input wire logic sys_clk,
    input wire logic rst_n,
    ref_cfg_if.sink cfg_port,
    input wire logic [CHANNELS-1:0] recovered_clk,
    input wire logic ext_clock_in,
    output logic ref_out,
    output logic ref_oe,
    output logic ext_is_e1
);

    typedef struct packed {
        logic out;
        logic oe;
        logic e1;
    } mux_state_s;

    mux_state_s st_q;
    mux_state_s st_d;

    always_comb
    begin
        st_d = st_q;
        // codes up to the last channel pick a recovered clock, the rest the external input
        if (cfg_port.cfg.select <= SEL_LAST_CHANNEL)
        begin
            st_d.out = recovered_clk[cfg_port.cfg.select]; // RULE_05 RULE_06
        end
        else
        begin
            st_d.out = ext_clock_in; // RULE_07
        end
        st_d.oe = cfg_port.cfg.enable; // RULE_01 RULE_02
        st_d.e1 = cfg_port.cfg.rate_e1; // RULE_03 RULE_04
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            st_q <= '{out: 1'b0, oe: ENABLE_RESET, e1: RATE_RESET};
        end
        else
        begin
            st_q <= st_d;
        end
    end

    assign ref_out = st_q.out;
    assign ref_oe = st_q.oe;
    assign ext_is_e1 = st_q.e1;

endmodule : ref_source_mux
`default_nettype wire

// ### tb/ref_pin_board.sv
// board pin model for one tri-stated reference output
// assumes a released pin floats, shown as the inverse of the last level
`timescale 1ns/1ps
`default_nettype none
module ref_pin_board (
    input wire logic sys_clk,
    input wire logic drv,
    input wire logic oe,
    output logic pin
);
    logic last_q = 1'b0;
    always_ff @(posedge sys_clk)
        if (oe)
            last_q <= drv;
    assign pin = oe ? drv : ~last_q;
endmodule : ref_pin_board
`default_nettype wire

// ### tb/ref_clock_asserts.sv
// assertions on the reference clock output select ports
// assumes it is bound into the top module and sees only that module's ports
`timescale 1ns/1ps
`default_nettype none
module ref_clock_asserts
    import ref_clock_pkg::*;
#(
    parameter int CHANNELS = NUM_CHANNELS
)
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [DATA_W-1:0] reg_rdata,
    input wire logic [CHANNELS-1:0] recovered_clk,
    input wire logic ext_clock_in_a,
    input wire logic ext_clock_in_b,
    input wire logic ref_clock_out_a,
    input wire logic ref_clock_out_a_oe,
    input wire logic ref_clock_out_b,
    input wire logic ref_clock_out_b_oe,
    input wire logic ext_input_a_rate_sel,
    input wire logic ext_input_b_rate_sel
);
    wire logic wa = reg_write && reg_addr == PRIMARY_CFG_ADDR;
    wire logic wb = reg_write && reg_addr == SECONDARY_CFG_ADDR;
    // sources as the outputs' flops saw them one edge back, so a moving source cannot fake a miss
    logic [CHANNELS-1:0] rclk_q;
    always_ff @(posedge sys_clk)
    begin
        rclk_q <= recovered_clk;
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    primary_enable_a: assert property (wa ##1 !reg_write |=> ref_clock_out_a_oe == $past(reg_wdata[6], 2))
        else $error("enable a");
    secondary_enable_a: assert property (wb ##1 !reg_write |=> ref_clock_out_b_oe == $past(reg_wdata[6], 2))
        else $error("enable b");
    primary_rate_a: assert property (wa ##1 !reg_write |=> ext_input_a_rate_sel == $past(reg_wdata[5], 2))
        else $error("rate a");
    secondary_rate_a: assert property (wb ##1 !reg_write |=> ext_input_b_rate_sel == $past(reg_wdata[5], 2))
        else $error("rate b");
    primary_source_a: assert property (wa && reg_wdata[4:0] <= SEL_LAST_CHANNEL ##1 !reg_write
        |=> ref_clock_out_a == rclk_q[$past(reg_wdata[4:0], 2)]) else $error("source a");
    secondary_source_a: assert property (wb && reg_wdata[4:0] <= SEL_LAST_CHANNEL ##1 !reg_write
        |=> ref_clock_out_b == rclk_q[$past(reg_wdata[4:0], 2)]) else $error("source b");
    external_route_a: assert property (wa && reg_wdata[4:0] > SEL_LAST_CHANNEL ##1 !reg_write
        |=> ref_clock_out_a == $past(ext_clock_in_a)) else $error("external a");
    secondary_external_a: assert property (wb && reg_wdata[4:0] > SEL_LAST_CHANNEL ##1 !reg_write
        |=> ref_clock_out_b == $past(ext_clock_in_b)) else $error("external b");
    reserved_bit_a: assert property (reg_read |=> !reg_rdata[RESERVED_BIT]) else $error("reserved bit");
    idle_rdata_a: assert property (!reg_read |=> reg_rdata == READ_UNMAPPED) else $error("idle read data");
endmodule : ref_clock_asserts
bind reference_clock_output_select ref_clock_asserts #(.CHANNELS(CHANNELS)) u_ref_clock_asserts (.*);
`default_nettype wire

// ### tb/testbench.sv
// self-checking bench for reference clock output selection
// assumes 20 MHz sys_clk and a one-cycle register read latency
`timescale 1ns/1ps
`default_nettype none
module testbench
    import ref_clock_pkg::*;
;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [11:0] reg_addr = 12'h000;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic [16:0] recovered_clk = 17'h00002;
    logic ext_clock_in_a = 1'b0;
    logic ext_clock_in_b = 1'b0;
    logic [7:0] reg_rdata;
    logic ref_clock_out_a, ref_clock_out_a_oe, ref_clock_out_b, ref_clock_out_b_oe;
    logic ext_input_a_rate_sel, ext_input_b_rate_sel, pin_a, pin_b;
    int n_mismatch = 0;
    int checks = 0;
    always #25 sys_clk = ~sys_clk;
    reference_clock_output_select u_reference_clock_output_select (.*);
    ref_pin_board u_ref_pin_board_a (.sys_clk, .drv(ref_clock_out_a), .oe(ref_clock_out_a_oe), .pin(pin_a));
    ref_pin_board u_ref_pin_board_b (.sys_clk, .drv(ref_clock_out_b), .oe(ref_clock_out_b_oe), .pin(pin_b));
    task check(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask : check
    task wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge sys_clk);
        reg_write <= 1'b0;
    endtask : wr
    task rd(input logic [11:0] a, input logic [7:0] e);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge sys_clk);
        reg_read <= 1'b0;
        @(negedge sys_clk);
        check(reg_rdata, e);
    endtask : rd
    task t_reset;
        rd(PRIMARY_CFG_ADDR, 8'h41);
        rd(SECONDARY_CFG_ADDR, 8'h41);
        check({4'h0, ref_clock_out_a_oe, ref_clock_out_b_oe, ext_input_a_rate_sel, ext_input_b_rate_sel}, 8'h0C);
        check({6'h00, pin_a, pin_b}, 8'h03);
    endtask : t_reset
    task t_fields;
        wr(PRIMARY_CFG_ADDR, 8'hA5);
        rd(PRIMARY_CFG_ADDR, 8'h25);
        wr(SECONDARY_CFG_ADDR, 8'h30);
        rd(SECONDARY_CFG_ADDR, 8'h30);
        check({4'h0, ref_clock_out_a_oe, ref_clock_out_b_oe, ext_input_a_rate_sel, ext_input_b_rate_sel}, 8'h03);
        wr(12'h248, 8'hFF);
        rd(12'h248, 8'h00);
        rd(PRIMARY_CFG_ADDR, 8'h25);
    endtask : t_fields
    // reset in mid-run must bring back every field, external select and E1 rate included
    task t_midreset;
        wr(PRIMARY_CFG_ADDR, 8'h3F);
        wr(SECONDARY_CFG_ADDR, 8'h22);
        @(posedge sys_clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge sys_clk);
        rst_n <= 1'b1;
        rd(PRIMARY_CFG_ADDR, 8'h41);
        rd(SECONDARY_CFG_ADDR, 8'h41);
        check({4'h0, ref_clock_out_a_oe, ref_clock_out_b_oe, ext_input_a_rate_sel, ext_input_b_rate_sel}, 8'h0C);
        check({6'h00, pin_a, pin_b}, 8'h03);
    endtask : t_midreset
    // every selector code on both outputs, source driven high then low
    task t_sweep;
        for (int c = 0; c < 32; c++)
        begin
            @(posedge sys_clk);
            recovered_clk <= (c < 17) ? 17'h00001 << c : 17'h00000;
            ext_clock_in_a <= c > 16;
            ext_clock_in_b <= c > 16;
            wr(PRIMARY_CFG_ADDR, 8'h40 | c[7:0]);
            wr(SECONDARY_CFG_ADDR, 8'h40 | c[7:0]);
            repeat (3) @(negedge sys_clk);
            check({6'h00, pin_a, pin_b}, 8'h03);
            @(posedge sys_clk);
            recovered_clk <= ~recovered_clk;
            ext_clock_in_a <= ~ext_clock_in_a;
            ext_clock_in_b <= ~ext_clock_in_b;
            repeat (3) @(negedge sys_clk);
            check({6'h00, pin_a, pin_b}, 8'h00);
        end
    endtask : t_sweep
    task print_verdict;
        $display("checks %0d n_mismatch %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : print_verdict
    initial
    begin
        repeat (8) @(posedge sys_clk);
        rst_n <= 1'b1;
        t_reset;
        t_fields;
        t_midreset;
        t_sweep;
        print_verdict;
    end
    initial
    begin
        #2000000;
        n_mismatch++;
        print_verdict;
    end
endmodule : testbench
`default_nettype wire
